// ===== msg_check_dec.sv
// Decoder end: serialises 21-bit information words onto the link.
// Assumes the user holds word_in stable while word_busy is high.
`timescale 1ns/1ps
module msg_check_dec
    import msg_check_pkg::*;
(
    msg_check_if.decoder link,
    input wire logic word_load,
    input wire logic [INFO_BITS-1:0] word_in,
    input wire logic first_word,
    input wire logic last_word,
    output logic word_busy
);
    import msg_check_pkg::*;
    typedef struct packed {
        logic [INFO_BITS-1:0] sh;
        logic [4:0] left;
        logic last;
        logic v;
        logic d;
        logic we;
        logic fs;
        logic fe;
        logic busy;
    } st_s;
    st_s st_ff;
    st_s nxt_st;
    always_comb begin
        nxt_st = st_ff;
        nxt_st.v = 1'b0;
        nxt_st.we = 1'b0;
        nxt_st.fs = 1'b0;
        nxt_st.fe = 1'b0;
        if (!st_ff.busy && word_load) begin
            nxt_st.sh = word_in;
            nxt_st.left = 5'(INFO_BITS);
            nxt_st.last = last_word;
            nxt_st.busy = 1'b1;
            nxt_st.fs = first_word;
        end else if (st_ff.busy) begin
            nxt_st.v = 1'b1;
            nxt_st.d = st_ff.sh[0];
            nxt_st.sh = st_ff.sh >> 1;
            nxt_st.left = st_ff.left - 5'h01;
            if (st_ff.left == 5'h01) begin
                nxt_st.we = 1'b1;
                nxt_st.busy = 1'b0;
                nxt_st.fe = st_ff.last;
            end
        end
    end
    always_ff @(posedge link.clk_sys or negedge link.nrst) begin
        if (!link.nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign link.bit_valid = st_ff.v;
    assign link.bit_data = st_ff.d;
    assign link.word_end = st_ff.we;
    assign link.frag_start = st_ff.fs;
    assign link.frag_end = st_ff.fe;
    assign word_busy = st_ff.busy;
endmodule // msg_check_dec

// ===== msg_check_host.sv
// Host-side checker: builds words, checks sums, tracks numbers.
// Assumes decoder end sends bits earliest first, one word = 21 bits.
`timescale 1ns/1ps
module msg_check_host
    import msg_check_pkg::*;
#(
    parameter int ADDR_W = 2
) (
    msg_check_if.host link,
    input wire logic [1:0] ck_kind,
    input wire logic [11:0] rx_check,
    input wire logic [1:0] uv_bits,
    input wire logic [1:0] frag_num,
    input wire logic cont_flag,
    input wire logic retr_flag,
    input wire logic [ADDR_W-1:0] addr_sel,
    input wire logic [5:0] msg_num,
    input wire logic [5:0] rollover,
    input wire logic [7:0] char_in,
    input wire logic char_valid,
    input wire logic char_tail,
    output logic check_err,
    output logic check_done,
    output logic missed_msg,
    output logic [5:0] missed_first,
    output logic [5:0] missed_last,
    output logic frag_missing,
    output logic msg_complete,
    output logic [1:0] char_mode,
    output logic char_split,
    output logic chan_err,
    output logic char_out_valid,
    output logic [7:0] char_out
);
    import msg_check_pkg::*;
    localparam int NADDR = 1 << ADDR_W;
    typedef struct packed {
        logic [INFO_BITS-1:0] shreg;
        logic [NADDR-1:0] seen;
        logic [NADDR-1:0][5:0] last_num;
        logic [NADDR-1:0][1:0] last_frag;
        logic [NADDR-1:0][5:0] frag_msg;
        logic err;
        logic done;
        logic missed;
        logic [5:0] mfirst;
        logic [5:0] mlast;
        logic fmiss;
        logic cmpl;
        logic [1:0] mode;
        logic split;
        logic cerr;
        logic cvalid;
        logic [7:0] cout;
    } st_s;
    st_s st_ff;
    st_s nxt_st;
    // Character classes as the tail filter sees them
    typedef enum logic [1:0] {
        CC_SHOW,
        CC_FILL,
        CC_NOISE,
        CC_PAD
    } char_cls_e;
    logic [SUM_W-1:0] sum;
    logic add_word;
    logic [INFO_BITS-1:0] word_full;
    logic [5:0] exp_num;
    logic [5:0] gap_last;
    logic [1:0] exp_frag;
    logic [11:0] calc_check;
    logic first_frag;
    logic num_break;
    logic frag_break;
    char_cls_e ch_cls;
    function automatic logic [5:0] inc_wrap(input logic [5:0] n,
                                            input logic [5:0] top);
        inc_wrap = (n >= top) ? 6'h00 : n + 6'h01;
    endfunction
    // Step back one number, wrapping from 0 to the roll-over value
    function automatic logic [5:0] dec_wrap(input logic [5:0] n,
                                            input logic [5:0] top);
        dec_wrap = (n == 6'h00) ? top : n - 6'h01;
    endfunction
    // Fragment numbers run 3 first, then 0, 1, 2 round and round
    function automatic logic [1:0] next_frag(input logic [1:0] f);
        next_frag = (f == 2'h2) ? 2'h0 : 2'(f + 2'h1);
    endfunction
    // Sort one character by its code and whether it sits in the tail
    function automatic char_cls_e classify(input logic [7:0] ch,
                                           input logic tail);
        if (ch == CH_NUL) begin
            classify = tail ? CC_FILL : CC_NOISE;
        end else if (ch == CH_ETX) begin
            classify = CC_PAD;
        end else begin
            classify = CC_SHOW;
        end
    endfunction
    function automatic logic [11:0] make_check(input logic [SUM_W-1:0] s,
                                               input logic [1:0] k);
        logic [7:0] low8;
        logic [6:0] fold;
        low8 = s[FOLD_KEEP-1:0];
        fold = 7'(low8 >> FOLD_SHIFT) + 7'(low8[FOLD_SHIFT-1:0]);
        case (k)
            CK_FULL6_FOLD: make_check = {6'h00, ~fold[5:0]};
            CK_FULL8: make_check = {4'h0, ~s[7:0]};
            CK_FULL10: make_check = {2'h0, ~s[9:0]};
            default: make_check = ~s[11:0];
        endcase
    endfunction
    // Earliest bit lands at bit 0 after 21 right shifts
    assign word_full = {link.bit_data, st_ff.shreg[INFO_BITS-1:1]};
    assign add_word = link.bit_valid && link.word_end;
    // The sum seen here already holds the word that ends this cycle, so
    // the last word of a fragment is counted at its fragment end
    msg_sum_acc u_acc (
        .clk_sys(link.clk_sys),
        .nrst(link.nrst),
        .clr(link.frag_start),
        .add(add_word),
        .word(word_full),
        .sum(sum)
    );
    assign calc_check = make_check(sum, ck_kind);
    assign first_frag = (frag_num == FRAG_FIRST);
    assign exp_num = inc_wrap(st_ff.last_num[addr_sel], rollover);
    assign gap_last = dec_wrap(msg_num, rollover);
    assign exp_frag = next_frag(st_ff.last_frag[addr_sel]);
    assign ch_cls = classify(char_in, char_tail);
    // A first message on an address has nothing to follow, so never flags
    assign num_break = retr_flag && st_ff.seen[addr_sel]
        && (msg_num != exp_num);
    // Continuations must carry the number of the message they extend
    assign frag_break = (msg_num != st_ff.frag_msg[addr_sel])
        || (frag_num != exp_frag);
    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        nxt_st.cvalid = 1'b0;
        nxt_st.missed = 1'b0;
        nxt_st.fmiss = 1'b0;
        nxt_st.cmpl = 1'b0;
        nxt_st.cerr = 1'b0;
        if (link.bit_valid) begin
            nxt_st.shreg = word_full;
        end
        if (link.frag_end) begin
            nxt_st.done = 1'b1;
            nxt_st.err = (calc_check != rx_check);
            nxt_st.cmpl = !cont_flag;
            nxt_st.last_frag[addr_sel] = frag_num;
            if (first_frag) begin
                // Control bits of a first fragment carry no meaning
                nxt_st.mode = UV_DEFAULT;
                nxt_st.split = 1'b0;
                nxt_st.frag_msg[addr_sel] = msg_num;
                if (num_break) begin
                    nxt_st.missed = 1'b1;
                    nxt_st.mfirst = exp_num;
                    nxt_st.mlast = gap_last;
                end
                // Messages with the retrieval flag clear leave the history untouched, so
                // the next numbered one is still judged against the last
                if (retr_flag) begin
                    nxt_st.seen[addr_sel] = 1'b1;
                    nxt_st.last_num[addr_sel] = msg_num;
                end
            end else begin
                // Continuations name their own character mode
                nxt_st.mode = uv_bits;
                case (uv_mode_e'(uv_bits))
                    UV_NONE: nxt_st.split = 1'b1;
                    UV_RESV: nxt_st.split = 1'b0;
                    UV_DEF: nxt_st.split = 1'b0;
                    default: nxt_st.split = 1'b0;
                endcase
                nxt_st.fmiss = frag_break;
            end
        end
        if (char_valid) begin
            case (ch_cls)
                CC_SHOW: begin
                    nxt_st.cvalid = 1'b1;
                    nxt_st.cout = char_in;
                end
                // Fill and padding vanish; an inner null is line damage
                CC_NOISE: nxt_st.cerr = 1'b1;
                CC_FILL: nxt_st.cerr = 1'b0;
                default: nxt_st.cvalid = 1'b0;
            endcase
        end
    end
    always_ff @(posedge link.clk_sys or negedge link.nrst) begin
        if (!link.nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    always_comb begin
        check_err = st_ff.err;
        check_done = st_ff.done;
        missed_msg = st_ff.missed;
        missed_first = st_ff.mfirst;
        missed_last = st_ff.mlast;
        frag_missing = st_ff.fmiss;
        msg_complete = st_ff.cmpl;
        char_mode = st_ff.mode;
        char_split = st_ff.split;
        chan_err = st_ff.cerr;
        char_out_valid = st_ff.cvalid;
        char_out = st_ff.cout;
    end
endmodule // msg_check_host

// ===== msg_check_if.sv
// Word link between the decoder side and the host-side checker.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
interface msg_check_if;
    logic clk_sys;
    logic nrst;
    logic bit_valid;
    logic bit_data;
    logic word_end;
    logic frag_start;
    logic frag_end;
    modport decoder (
        input clk_sys,
        input nrst,
        output bit_valid,
        output bit_data,
        output word_end,
        output frag_start,
        output frag_end
    );
    modport host (
        input clk_sys,
        input nrst,
        input bit_valid,
        input bit_data,
        input word_end,
        input frag_start,
        input frag_end
    );
endinterface

// ===== msg_check_pkg.sv
// Constants and types shared by the message check ends.
// Assumes one 40 MHz clock and an active-low asynchronous reset.
// Behaviour
// - Receiver strips trailing null fill characters
// - Inner null characters mean channel error
// - Last fragment pads with end-of-text or null
// - First fragment starts in default mode
// - Read control bits from continuation fragments
// - Decode control pair: 00,01,10,11 meanings
// - Mode 00 lets characters straddle fragments
// - Checksum sums every information bit
// - Groups are bits 0-7, 8-15, 16-20
// - First received bit is bit 0
// - Checksum is complement of low sum bits
// - Numeric checksum folds top two bits
// - Message numbers 0..63 wrap at roll-over
// - Out-of-sequence number flags missed messages
// - Retrieval flag clear skips sequence check
// - Track message numbers per address
// - Fragment numbers go 3, then 0,1,2
// - Continue flag clear completes message
package msg_check_pkg;
    localparam int INFO_BITS = 21;
    localparam int SUM_W = 16;
    localparam int G2_LSB = 8;
    localparam int G3_LSB = 16;
    localparam int NUM_W = 6;
    localparam int FOLD_KEEP = 8;
    localparam int FOLD_SHIFT = 6;
    localparam logic [7:0] CH_NUL = 8'h00;
    localparam logic [7:0] CH_ETX = 8'h03;
    localparam logic [1:0] FRAG_FIRST = 2'h3;
    localparam logic [1:0] UV_DEFAULT = 2'h2;
    localparam logic [5:0] MSGNUM_MAX = 6'h3f;
    typedef enum logic [1:0] {
        UV_NONE,
        UV_RESV,
        UV_DEF,
        UV_ALT
    } uv_mode_e;
    typedef enum logic [1:0] {
        CK_FULL8,
        CK_FULL6_FOLD,
        CK_FULL10,
        CK_FULL12
    } ck_kind_e;
endpackage

// ===== msg_check_props.sv
// Checker for the word link between the two message check ends.
// Assumes it sits beside the link and sees its signals only.
`timescale 1ns/1ps
module msg_check_props (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic bit_valid,
    input wire logic bit_data,
    input wire logic word_end,
    input wire logic frag_start,
    input wire logic frag_end
);
    logic [4:0] bcnt_ff;
    logic in_frag_ff;
    // Bits since the last word end; a short word would skew group sums
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            bcnt_ff <= 5'h00;
            in_frag_ff <= 1'b0;
        end else begin
            bcnt_ff <= word_end ? 5'h00 : bcnt_ff + {4'h0, bit_valid};
            in_frag_ff <= frag_start | (in_frag_ff & ~frag_end);
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    property p_end_bit; word_end |-> bit_valid; endproperty
    a_end_bit: assert property (p_end_bit)
        else $error("word end without a bit");
    property p_word_len; word_end |-> bcnt_ff == 5'h14; endproperty
    a_word_len: assert property (p_word_len)
        else $error("word is not 21 bits");
    property p_bit_cap; bit_valid |-> bcnt_ff <= 5'h14; endproperty
    a_bit_cap: assert property (p_bit_cap)
        else $error("bit beyond word length");
    property p_run; $rose(bit_valid) |-> bit_valid[*8]; endproperty
    a_run: assert property (p_run)
        else $error("word bits not back to back");
    property p_gap; word_end |=> !bit_valid; endproperty
    a_gap: assert property (p_gap)
        else $error("bit right after word end");
    property p_fs_lead; frag_start |=> bit_valid; endproperty
    a_fs_lead: assert property (p_fs_lead)
        else $error("no bit after fragment start");
    property p_fs_idle; frag_start |-> !bit_valid && bcnt_ff == 5'h00;
    endproperty
    a_fs_idle: assert property (p_fs_idle)
        else $error("fragment start inside a word");
    property p_fe_end; frag_end |-> word_end && in_frag_ff; endproperty
    a_fe_end: assert property (p_fe_end)
        else $error("fragment end off a word end");
    c_frag: cover property (frag_end);
    c_start: cover property (frag_start ##1 bit_valid);
    c_mid: cover property (word_end && !frag_end);
endmodule // msg_check_props

// ===== msg_sum_acc.sv
// Checksum accumulator: adds the three bit groups of each word.
// Assumes words arrive complete in parallel form.
`timescale 1ns/1ps
module msg_sum_acc
    import msg_check_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clr,
    input wire logic add,
    input wire logic [INFO_BITS-1:0] word,
    output logic [SUM_W-1:0] sum
);
    typedef struct packed {
        logic [SUM_W-1:0] sum;
    } st_s;
    st_s st_ff;
    st_s nxt_st;
    always_comb begin
        nxt_st = st_ff;
        if (clr) begin
            nxt_st.sum = '0;
        end
        if (add) begin
            nxt_st.sum = (clr ? SUM_W'(0) : st_ff.sum)
                + SUM_W'(word[G2_LSB-1:0])
                + SUM_W'(word[G3_LSB-1:G2_LSB])
                + SUM_W'(word[INFO_BITS-1:G3_LSB]);
        end
    end
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    // Shows the sum as it stands after this cycle, so a word that ends
    // together with its fragment is already counted in it
    assign sum = nxt_st.sum;
endmodule // msg_sum_acc

// ===== test_message_checksum_fragment_check.sv
// Testbench: decoder end feeds the host checker over the word link.
// Assumes package, link and both ends are compiled first.
`timescale 1ns/1ps
module test_message_checksum_fragment_check;
    import msg_check_pkg::*;
    logic clk_sys, word_busy, check_err, check_done, missed_msg;
    logic frag_missing, msg_complete, char_split, chan_err;
    logic char_out_valid;
    logic [5:0] missed_first, missed_last;
    logic [1:0] char_mode;
    logic [7:0] char_out;
    logic nrst = 1'b0, word_load = 1'b0, first_word = 1'b0;
    logic last_word = 1'b0, cont_flag = 1'b0, retr_flag = 1'b0;
    logic char_valid = 1'b0, char_tail = 1'b0;
    logic [20:0] word_in = 21'h0;
    logic [1:0] ck_kind = 2'h0, uv_bits = 2'h0, frag_num = 2'h3;
    logic [1:0] addr_sel = 2'h0;
    logic [11:0] rx_check = 12'h0;
    logic [5:0] msg_num = 6'h0, rollover = 6'h3f;
    logic [7:0] char_in = 8'h0;
    logic [20:0] wd [3] = '{21'h1fffff, 21'h0a5c3e, 21'h10f00d};
    logic [5:0] mt [5] = '{6'h00, 6'h03, 6'h09, 6'h04, 6'h00};
    logic [1:0] ft [5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h2};
    logic [7:0] ct [4] = '{8'h41, CH_NUL, CH_NUL, CH_ETX};
    logic [15:0] s3;
    int n_errors = 0, cmp_count = 0, cyc = 0;
    msg_check_if link ();
    assign link.clk_sys = clk_sys;
    assign link.nrst = nrst;
    msg_check_dec msg_check_dec_i (.link(link), .word_load, .word_in,
        .first_word, .last_word, .word_busy);
    msg_check_host msg_check_host_i (.link(link), .ck_kind, .rx_check,
        .uv_bits, .frag_num, .cont_flag, .retr_flag, .addr_sel, .msg_num,
        .rollover, .char_in, .char_valid, .char_tail, .check_err,
        .check_done, .missed_msg, .missed_first, .missed_last,
        .frag_missing, .msg_complete, .char_mode, .char_split, .chan_err,
        .char_out_valid, .char_out);
    msg_check_props msg_check_props_i (.clk_sys(link.clk_sys),
        .nrst(link.nrst), .bit_valid(link.bit_valid),
        .bit_data(link.bit_data), .word_end(link.word_end),
        .frag_start(link.frag_start), .frag_end(link.frag_end));
    function automatic logic [15:0] gs(input logic [20:0] w);
        gs = {8'h0, w[7:0]} + {8'h0, w[15:8]} + {11'h0, w[20:16]};
    endfunction
    function automatic logic [11:0] cks(input logic [1:0] k,
                                        input logic [15:0] s);
        logic [7:0] f;
        f = {2'h0, s[5:0]} + {6'h00, s[7:6]};
        case (k)
            2'h0: cks = {4'h0, ~s[7:0]};
            2'h1: cks = {6'h00, ~f[5:0]};
            2'h2: cks = {2'h0, ~s[9:0]};
            default: cks = ~s[11:0];
        endcase
    endfunction
    task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Sends nw words as one fragment; returns when host outputs stand
    task automatic send(input int nw);
        logic [20:0] cap;
        int t;
        for (int i = 0; i < nw; i++) begin
            while (word_busy) @(posedge clk_sys);
            word_load <= 1'b1;
            word_in <= wd[i];
            first_word <= (i == 0);
            last_word <= (i == nw - 1);
            @(posedge clk_sys);
            word_load <= 1'b0;
            t = 0;
            do begin
                @(posedge clk_sys);
                if (t == 0) chk(word_busy, 1'b1);
                if (link.bit_valid) cap = {link.bit_data, cap[20:1]};
                t++;
            end while (!link.word_end && t < 40);
            chk(cap, wd[i]);
        end
        @(posedge clk_sys);
    endtask
    task automatic chr(input logic [7:0] c, input logic tl);
        char_in <= c;
        char_tail <= tl;
        char_valid <= 1'b1;
        @(posedge clk_sys);
        char_valid <= 1'b0;
        @(posedge clk_sys);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_errors++;
            wrap_up();
        end
    end
    initial begin
        s3 = gs(wd[0]) + gs(wd[1]) + gs(wd[2]);
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            ck_kind <= k[2:1];
            msg_num <= k[5:0];
            rx_check <= cks(k[2:1], s3) ^ {11'h0, k[0]};
            send(3);
            chk(check_done, 1'b1);
            chk(check_err, k[0]);
            chk(msg_complete, 1'b1);
            chk(char_mode, UV_DEFAULT);
        end
        addr_sel <= 2'h1;
        rollover <= 6'h04;
        for (int i = 0; i < 5; i++) begin
            msg_num <= mt[i];
            retr_flag <= (i != 2);
            send(1);
            chk(missed_msg, i == 1);
            if (i == 1) begin
                chk(missed_first, 6'h01);
                chk(missed_last, 6'h02);
            end
        end
        addr_sel <= 2'h2;
        msg_num <= 6'h07;
        retr_flag <= 1'b0;
        cont_flag <= 1'b1;
        send(1);
        chk(msg_complete, 1'b0);
        for (int u = 0; u < 5; u++) begin
            frag_num <= ft[u];
            uv_bits <= u[1:0];
            cont_flag <= (u != 4);
            send(1);
            chk(frag_missing, u == 4);
            chk(char_mode, u[1:0]);
            chk(char_split, u[1:0] == 2'h0);
        end
        for (int c = 0; c < 4; c++) begin
            chr(ct[c], c > 1);
            chk(char_out_valid, c == 0);
            chk(chan_err, c == 1);
            if (c == 0) chk(char_out, 8'h41);
        end
        wrap_up();
    end
endmodule // test_message_checksum_fragment_check
